// [rtl/spzu_pkg.sv]
/*
  Constants and types of serial port zero.
  Assumes one clock and a 32-bit AHB-Lite bus.
*/
// What this block does
// RULE1: Two mode bits select sync 8-bit, async 10-bit, async 11-bit fixed or variable.
// RULE2: With framing select set, control bit 7 is a framing error flag, software cleared.
// RULE3: Modes 2 and 3 with multiproc set: no receive flag when ninth bit is zero.
// RULE4: Mode 1 with multiproc set: no receive flag unless stop bit valid.
// RULE5: Mode 0: multiproc bit picks shift clock of oscillator over 12 or over 4.
// RULE6: Reception happens only while the receive enable bit is one.
// RULE7: Modes 2 and 3 transmit the software ninth bit as ninth data bit.
// RULE8: Received ninth bit in modes 2/3; stop bit in mode 1 without multiproc.
// RULE9: Transmit flag set after eighth bit in mode 0, else at stop start.
// RULE10: Receive flag set after eighth bit in mode 0, else mid stop, filtered.
// RULE11: Data buffer reads give receive register, writes load the transmit buffer.
// RULE12: Address bits are compared only where the mask bit is one.
// RULE13: An all-zero mask makes any address a match.
// RULE14: Serial request reaches the core only with serial and global enables set.
// RULE15: Serial priority bit one places the request at the high level.
// RULE16: Transmit leaves on port 3 bit 1, receive enters on port 3 bit 0; in mode 0 the code shifts data both ways on bit 0, shift clock on bit 1.
// RULE17: Modes 1 and 3 use an external overflow tick, receiver oversampled 16x.
// RULE18: Address match applies to mode 2/3 frames with multiproc set, gating the flag.
package spzu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL   = 8'h98;
  localparam logic [7:0] IDX_DATA      = 8'h99;
  localparam logic [7:0] IDX_IRQ_EN    = 8'hA8;
  localparam logic [7:0] IDX_GIVEN     = 8'hA9;
  localparam logic [7:0] IDX_IRQ_PRIO  = 8'hB8;
  localparam logic [7:0] IDX_MASK      = 8'hB9;
  localparam logic [7:0] IDX_POWER     = 8'h87;
  localparam logic [7:0] IDX_EVT_STAT  = 8'hF0;
  localparam logic [7:0] IDX_EVT_MASK  = 8'hF1;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int IE_GLOBAL_BIT   = 7;
  localparam int IE_SERIAL_BIT   = 4;
  localparam int IP_SERIAL_BIT   = 4;
  localparam int POWER_CONTROL_REG_DOUBLE_BIT = 7;
  localparam int POWER_CONTROL_REG_FRAME_BIT  = 6;
  localparam int EVT_TX_BIT      = 0;
  localparam int EVT_RX_BIT      = 1;
  localparam int EVT_FE_BIT      = 2;
  localparam logic [7:0] IP_READ_ONES = 8'h80;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Mode codes, clock period and timing counts in clocks or sample ticks
  localparam logic [1:0] MODE_SYNC8  = 2'h0;
  localparam logic [1:0] MODE_ASYNC1 = 2'h1;
  localparam logic [1:0] MODE_FIXED2 = 2'h2;
  localparam int CLK_PERIOD_NS       = 10;
  localparam logic [3:0] M0_DIV_SLOW = 4'hC;
  localparam logic [3:0] M0_DIV_FAST = 4'h4;
  localparam logic [3:0] OVERSAMPLE  = 4'h0;
  localparam logic [3:0] SAMPLE_MID  = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'hF;
  localparam logic [2:0] M2_TICK_64  = 3'h4;
  localparam logic [2:0] M2_TICK_32  = 3'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Serial control register layout, bit 7 first
  typedef struct packed {
    logic mode_sel_hi;
    logic mode_sel_lo;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } spzu_ctrl_type;

  typedef enum logic [2:0] {
    FR_IDLE, FR_START, FR_DATA, FR_NINTH, FR_STOP
  } spzu_frame_type;

  typedef enum logic {M0_IDLE, M0_SHIFT} spzu_sync_type;

endpackage

// [rtl/spzu_top.sv]
/*
  Serial port zero: four-mode serial engine and its registers on AHB-Lite.
  Assumes inputs synchronous to hclk; baud_tick pulses at 16x bit rate.
*/
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module spzu_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        baud_tick,
  input  wire logic        rxd_in,
  output logic             rxd_out,
  output logic             rxd_oe,
  output logic             txd,
  output logic             irq,
  output logic             serial_irq_request,
  output logic             serial_irq_high
);
  import spzu_pkg::*;

  spzu_ctrl_type  ctrl;
  spzu_frame_type tx_state;
  spzu_frame_type rx_state;
  spzu_sync_type  m0_state;
  logic       framing_error_flag;
  logic [7:0] rx_data;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_priority_reg;
  logic [7:0] addr_compare_mask;
  logic [7:0] given_addr_match;
  logic [7:0] power_control_reg;
  logic [7:0] evt_status;
  logic [7:0] evt_mask;
  logic       wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] wdata;
  logic [7:0] rd_mux;
  logic [7:0] rd_idx;
  logic       addr_ok;
  logic       in_map;
  logic [1:0] mode;
  logic       mode0;
  logic       framing_select;
  logic       wr_data;
  logic [2:0] div_cnt;
  logic       div_tick;
  logic       samp_tick;
  logic [3:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [8:0] tx_sh;
  logic       tx_line;
  logic       tx_set;
  logic [3:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic       rx_ninth;
  logic       rx_last;
  logic       rx_load;
  logic       rx_flag_set;
  logic       fe_set;
  logic       rx_new_ninth;
  logic       addr_match;
  logic       stop_ok;
  logic       accept;
  logic [3:0] m0_div;
  logic [3:0] m0_cnt;
  logic [2:0] m0_bit;
  logic [7:0] m0_sh;
  logic       m0_rx;
  logic       m0_end;
  logic [7:0] evt_set;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: address phase taken when selected and ready
  assign addr_ok = hsel & hready & htrans[1];
  assign rd_idx  = haddr[9:2];
  assign in_map  = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
  assign wdata   = hwdata[7:0];
  assign wr_data = wr_pend & (wr_idx == IDX_DATA);

  // Latch write address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 8'h00;
    end else begin
      wr_pend <= addr_ok & hwrite & in_map;
      wr_idx  <= rd_idx;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 8'h00;
    case (rd_idx)
      IDX_CONTROL:  rd_mux = {(framing_select ? framing_error_flag
                                              : ctrl.mode_sel_hi),
                              ctrl[6:0]};                      // RULE2
      IDX_DATA:     rd_mux = rx_data;                          // RULE11
      IDX_IRQ_EN:   rd_mux = irq_enable_reg;
      IDX_GIVEN:    rd_mux = given_addr_match;
      IDX_IRQ_PRIO: rd_mux = irq_priority_reg | IP_READ_ONES;
      IDX_MASK:     rd_mux = addr_compare_mask;
      IDX_POWER:    rd_mux = power_control_reg;
      IDX_EVT_STAT: rd_mux = evt_status;
      IDX_EVT_MASK: rd_mux = evt_mask;
      default:      rd_mux = 8'h00;
    endcase
  end

  // Zero-wait OKAY answer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (addr_ok & !hwrite & in_map) ? {24'h0, rd_mux} : 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_reg    <= RESET_BYTE;
      irq_priority_reg  <= RESET_BYTE;
      addr_compare_mask <= RESET_BYTE;
      given_addr_match  <= RESET_BYTE;
      power_control_reg <= RESET_BYTE;
      evt_mask          <= RESET_BYTE;
    end else if (wr_pend) begin
      case (wr_idx)
        IDX_IRQ_EN:   irq_enable_reg    <= wdata;
        IDX_IRQ_PRIO: irq_priority_reg  <= wdata;
        IDX_MASK:     addr_compare_mask <= wdata;
        IDX_GIVEN:    given_addr_match  <= wdata;
        IDX_POWER:    power_control_reg <= wdata;
        IDX_EVT_MASK: evt_mask          <= wdata;
        default:      ;
      endcase
    end
  end

  assign framing_select = power_control_reg[POWER_CONTROL_REG_FRAME_BIT];
  assign mode  = {ctrl.mode_sel_hi, ctrl.mode_sel_lo};               // RULE1
  assign mode0 = (mode == MODE_SYNC8);

  ////////////////////////////////////////////////////////////////////////////
  // Serial control; hardware sets win
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0;
    end else begin
      if (wr_pend && wr_idx == IDX_CONTROL) begin
        ctrl[6:0] <= wdata[6:0];
        if (!framing_select) begin
          ctrl.mode_sel_hi <= wdata[7];
        end
      end
      if (rx_load) begin
        ctrl.rx_ninth_bit <= rx_new_ninth;                           // RULE8
      end
      if (tx_set) begin
        ctrl.tx_done_flag <= 1'b1;                                   // RULE9
      end
      if (rx_flag_set) begin
        ctrl.rx_done_flag <= 1'b1;                                   // RULE10
      end
    end
  end

  // Framing error flag; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      framing_error_flag <= 1'b0;
    end else if (fe_set) begin
      framing_error_flag <= 1'b1;                                    // RULE2
    end else if (wr_pend && wr_idx == IDX_CONTROL && framing_select) begin
      framing_error_flag <= wdata[7];                                // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample tick: divider in mode 2, else external
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt  <= 3'h0;
      div_tick <= 1'b0;
    end else begin
      div_tick <= 1'b0;
      if (div_cnt == (power_control_reg[POWER_CONTROL_REG_DOUBLE_BIT] ? M2_TICK_32
                                                         : M2_TICK_64)
                     - 3'h1) begin
        div_cnt  <= 3'h0;
        div_tick <= 1'b1;                                            // RULE1
      end else begin
        div_cnt <= div_cnt + 3'h1;
      end
    end
  end

  assign samp_tick = (mode == MODE_FIXED2) ? div_tick : baud_tick;  // RULE17

  ////////////////////////////////////////////////////////////////////////////
  // Asynchronous transmitter; a write while busy is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state <= FR_IDLE;
      tx_cnt   <= 4'h0;
      tx_bit   <= 3'h0;
      tx_sh    <= 9'h1FF;
      tx_line  <= 1'b1;
      tx_set   <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      case (tx_state)
        FR_IDLE: begin
          tx_line <= 1'b1;
          if (wr_data && !mode0) begin
            tx_sh    <= {ctrl.tx_ninth_bit, wdata};                  // RULE7
            tx_cnt   <= OVERSAMPLE;
            tx_state <= FR_START;
          end
        end
        default: begin
          if (tx_state == FR_START) begin
            tx_line <= 1'b0;
          end
          if (samp_tick) begin
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt == SAMPLE_LAST) begin
              case (tx_state)
                FR_START: begin
                  tx_state <= FR_DATA;
                  tx_bit   <= 3'h0;
                  tx_line  <= tx_sh[0];
                end
                FR_DATA: begin
                  tx_bit <= tx_bit + 3'h1;
                  if (tx_bit == 3'h7) begin
                    if (mode[1]) begin
                      tx_state <= FR_NINTH;
                      tx_line  <= tx_sh[8];                          // RULE7
                    end else begin
                      tx_state <= FR_STOP;
                      tx_line  <= 1'b1;
                      tx_set   <= 1'b1;                              // RULE9
                    end
                  end else begin
                    tx_line <= tx_sh[tx_bit + 3'h1];
                  end
                end
                FR_NINTH: begin
                  tx_state <= FR_STOP;
                  tx_line  <= 1'b1;
                  tx_set   <= 1'b1;                                  // RULE9
                end
                default: begin
                  tx_state <= FR_IDLE;
                end
              endcase
            end
          end
        end
      endcase
      if (m0_end && !m0_rx) begin
        tx_set <= 1'b1;                                              // RULE9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiprocessor filter and address match
  assign addr_match   = ((rx_sh ^ given_addr_match) & addr_compare_mask)
                        == 8'h00;                                    // RULE12 RULE13
  assign stop_ok      = rxd_in;
  assign rx_new_ninth = mode[1] ? rx_ninth : stop_ok;                // RULE8
  always_comb begin
    accept = 1'b1;
    if (mode == MODE_ASYNC1) begin
      accept = !ctrl.multiproc_enable | stop_ok;                     // RULE4
    end else if (ctrl.multiproc_enable) begin
      accept = rx_ninth & addr_match;                                // RULE3 RULE18
    end
  end

  // Receiver, 16x oversampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= FR_IDLE;
      rx_cnt   <= 4'h0;
      rx_bit   <= 3'h0;
      rx_sh    <= 8'h00;
      rx_ninth <= 1'b0;
      rx_last  <= 1'b1;
      fe_set   <= 1'b0;
    end else begin
      fe_set <= 1'b0;
      if (samp_tick) begin
        rx_last <= rxd_in;
      end
      if (!ctrl.rx_enable || mode0) begin
        rx_state <= FR_IDLE;                                         // RULE6
      end else if (samp_tick) begin
        rx_cnt <= rx_cnt + 4'h1;
        case (rx_state)
          FR_IDLE: begin
            if (rx_last && !rxd_in) begin
              rx_state <= FR_START;
              rx_cnt   <= 4'h1;
            end
          end
          FR_START: begin
            if (rx_cnt == SAMPLE_MID && rxd_in) begin
              rx_state <= FR_IDLE;
            end else if (rx_cnt == SAMPLE_LAST) begin
              rx_state <= FR_DATA;
              rx_bit   <= 3'h0;
            end
          end
          FR_DATA: begin
            if (rx_cnt == SAMPLE_MID) begin
              rx_sh <= {rxd_in, rx_sh[7:1]};
            end
            if (rx_cnt == SAMPLE_LAST) begin
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == 3'h7) begin
                rx_state <= mode[1] ? FR_NINTH : FR_STOP;
              end
            end
          end
          FR_NINTH: begin
            if (rx_cnt == SAMPLE_MID) begin
              rx_ninth <= rxd_in;                                    // RULE8
            end
            if (rx_cnt == SAMPLE_LAST) begin
              rx_state <= FR_STOP;
            end
          end
          FR_STOP: begin
            if (rx_cnt == SAMPLE_MID) begin
              rx_state <= FR_IDLE;
              fe_set   <= !stop_ok;                                  // RULE2
            end
          end
          default: rx_state <= FR_IDLE;
        endcase
      end
    end
  end

  // Buffer load and receive flag
  assign rx_load = (m0_end & m0_rx) |
                   (samp_tick & ctrl.rx_enable & !mode0 &
                    (rx_state == FR_STOP) & (rx_cnt == SAMPLE_MID) &
                    !ctrl.rx_done_flag & accept);                    // RULE10
  assign rx_flag_set = rx_load;

  // Receive register, written only by hardware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_data <= 8'h00;
    end else if (m0_end && m0_rx) begin
      rx_data <= m0_sh;                                              // RULE11
    end else if (rx_load) begin
      rx_data <= rx_sh;                                              // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode 0 shift engine
  assign m0_div = ctrl.multiproc_enable ? M0_DIV_FAST : M0_DIV_SLOW; // RULE5
  assign m0_end = (m0_state == M0_SHIFT) & (m0_cnt == m0_div - 4'h1) &
                  (m0_bit == 3'h7);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m0_state <= M0_IDLE;
      m0_cnt   <= 4'h0;
      m0_bit   <= 3'h0;
      m0_sh    <= 8'h00;
      m0_rx    <= 1'b0;
    end else begin
      case (m0_state)
        M0_IDLE: begin
          m0_cnt <= 4'h0;
          m0_bit <= 3'h0;
          if (mode0 && wr_data) begin
            m0_sh    <= wdata;
            m0_rx    <= 1'b0;
            m0_state <= M0_SHIFT;
          end else if (mode0 && ctrl.rx_enable && !ctrl.rx_done_flag) begin
            m0_rx    <= 1'b1;                                        // RULE6
            m0_state <= M0_SHIFT;
          end
        end
        M0_SHIFT: begin
          m0_cnt <= m0_cnt + 4'h1;
          if (m0_rx && m0_cnt == (m0_div >> 1) - 4'h1) begin
            m0_sh <= {rxd_in, m0_sh[7:1]};
          end
          if (m0_cnt == m0_div - 4'h1) begin
            m0_cnt <= 4'h0;
            m0_bit <= m0_bit + 3'h1;
            if (!m0_rx) begin
              m0_sh <= {1'b1, m0_sh[7:1]};
            end
            if (m0_bit == 3'h7 || !mode0) begin
              m0_state <= M0_IDLE;
            end
          end
        end
        default: m0_state <= M0_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers: transmit pin P3.1, receive pin P3.0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd     <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else begin
      if (m0_state == M0_SHIFT) begin
        txd <= (m0_cnt >= (m0_div >> 1));                            // RULE16
      end else begin
        txd <= mode0 ? 1'b1 : tx_line;                               // RULE16
      end
      rxd_oe  <= (m0_state == M0_SHIFT) & !m0_rx;
      rxd_out <= ((m0_state == M0_SHIFT) & !m0_rx) ? m0_sh[0] : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear
  always_comb begin
    evt_set = 8'h00;
    evt_set[EVT_TX_BIT] = tx_set;
    evt_set[EVT_RX_BIT] = rx_flag_set;
    evt_set[EVT_FE_BIT] = fe_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_status <= RESET_BYTE;
    end else if (wr_pend && wr_idx == IDX_EVT_STAT) begin
      evt_status <= (evt_status & ~wdata) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  // Interrupt outputs to the core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq                <= 1'b0;
      serial_irq_request <= 1'b0;
      serial_irq_high    <= 1'b0;
    end else begin
      irq                <= |(evt_status & evt_mask);
      serial_irq_request <= (ctrl.tx_done_flag | ctrl.rx_done_flag) &
                            irq_enable_reg[IE_SERIAL_BIT] &
                            irq_enable_reg[IE_GLOBAL_BIT];           // RULE14
      serial_irq_high    <= irq_priority_reg[IP_SERIAL_BIT];         // RULE15
    end
  end

endmodule

// [testbench/spzu_node.sv]
/*
  Remote serial node: 64 clocks a bit.
  Assumes mode 2 single speed or a tick each 4 clocks.
*/
`timescale 1ns/1ns
module spzu_node (
  input  wire logic       hclk,
  input  wire logic       txd,
  input  wire logic       listen,
  output logic            rxd_in,
  output logic [8:0]      got,
  output logic            got_v
);
  initial begin
    rxd_in = 1'b1;
    got = 9'h000;
    got_v = 1'b0;
  end
  // Send one frame LSB first, ninth bit, then stop; idle high
  task automatic send(input logic [8:0] d, input logic stp);
    logic [10:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_in <= f[i];
      repeat (64) @(posedge hclk);
    end
    rxd_in <= 1'b1;
  endtask
  // Sample each data bit and the ninth bit at its middle
  always @(negedge txd) begin
    if (listen) begin
      repeat (32) @(posedge hclk);
      for (int k = 0; k < 9; k++) begin
        repeat (64) @(posedge hclk);
        got[k] <= txd;
      end
      got_v <= 1'b1;
      @(posedge hclk);
      got_v <= 1'b0;
    end
  end
endmodule

// [testbench/spzu_top_asserts.sv]
/*
  Checker of serial port zero on its top ports.
  Assumes hready tied to hreadyout.
*/
`timescale 1ns/1ns
module spzu_chk
  import spzu_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxd_out,
  input wire logic        rxd_oe,
  input wire logic        serial_irq_request,
  input wire logic        serial_irq_high
);
  logic       rd_p;
  logic       wr_p;
  logic [7:0] ph_i;
  logic [7:0] ie_q;
  logic [7:0] ip_q;
  ////////////////////////////////////////////////////////////////////////
  // Data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_p <= 1'b0;
      wr_p <= 1'b0;
      ph_i <= 8'h00;
    end else if (hreadyout) begin
      rd_p <= hsel && htrans[1] && !hwrite;
      wr_p <= hsel && htrans[1] && hwrite;
      ph_i <= haddr[9:2];
    end
  end
  // Shadow copies of enable and priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ie_q <= 8'h00;
      ip_q <= 8'h00;
    end else if (wr_p && ph_i == IDX_IRQ_EN) begin
      ie_q <= hwdata[7:0];
    end else if (wr_p && ph_i == IDX_IRQ_PRIO) begin
      ip_q <= hwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence prio_read_s;
    rd_p && ph_i == IDX_IRQ_PRIO;
  endsequence
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  no_wait_a: assert property (hreadyout)
    else $error("slave inserted a wait");
  idle_zero_a: assert property (!rd_p |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  upper_zero_a: assert property (rd_p |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  prio_ones_a: assert property (prio_read_s |-> hrdata[7])
    else $error("priority bit seven reads low");
  irq_gate_a: assert property (serial_irq_request |->
    $past(ie_q[IE_GLOBAL_BIT] && ie_q[IE_SERIAL_BIT]))
    else $error("request without both enables");
  prio_level_a: assert property (##1 serial_irq_high ==
    $past(ip_q[IP_SERIAL_BIT]))
    else $error("priority level wrong");
  pin_release_a: assert property (!rxd_oe |-> rxd_out)
    else $error("receive pin not released high");
endmodule
bind spzu_top spzu_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe),
  .serial_irq_request(serial_irq_request),
  .serial_irq_high(serial_irq_high));

// [testbench/tb_top.sv]
/*
  Self-checking bench of serial port zero.
  Assumes 64-clock bits on the link.
*/
`timescale 1ns/1ns
module tb_top;
  import spzu_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, baud_tick, listen, rdp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        hreadyout, hresp, rxd_in, rxd_out, rxd_oe, txd, irq;
  logic        sreq, shigh, got_v;
  logic [8:0]  got;
  logic [7:0]  tx, rx;
  logic [15:0] e;
  logic [15:0] rq[$];
  logic [8:0]  tq[$];
  int          bad_count, check_count, n;
  logic [15:0] cs[7] = '{16'hB800, 16'hB800, 16'hB8F0, 16'hB8F0, 16'h8800,
                         16'hF800, 16'h7800};
  logic [8:0]  fr[7] = '{9'h033, 9'h1C4, 9'h15A, 9'h16A, 9'h0E1, 9'h1C4,
                         9'h0AA};
  logic [7:0]  ex[7] = '{8'hB8, 8'hB9, 8'hB9, 8'hB8, 8'h88, 8'hF9, 8'h78};
  spzu_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .baud_tick(baud_tick), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .irq(irq),
    .serial_irq_request(sreq), .serial_irq_high(shigh));
  spzu_node u_node (.hclk(hclk), .txd(txd), .listen(listen),
    .rxd_in(rxd_in), .got(got), .got_v(got_v));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One single word transfer, held until hready is seen high
  task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e,
                    input logic [7:0] m);
    rq.push_back({m, e});
    bus(i, 1'b0, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
  // Result watcher: oldest note against each read or frame
  always @(posedge hclk) begin
    if (rdp) begin
      e = rq.pop_front();
      chk(hrdata[7:0] & e[15:8], e[7:0] & e[15:8]);
    end
    if (got_v) chk(got, tq.pop_front());
    rdp <= hsel && htrans[1] && !hwrite && hreadyout;
    baud_tick <= ($time / 10) % 4 == 0;
  end
  // Main sequence
  initial begin
    void'($urandom(59));
    {hresetn, hsel, hwrite, baud_tick, listen, rdp} = 6'h00;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_CONTROL, RESET_BYTE, 8'hFF);
    rd(IDX_IRQ_PRIO, IP_READ_ONES, 8'hFF);
    rd(8'h10, 8'h00, 8'hFF);
    bus(IDX_EVT_MASK, 1'b1, 8'h07);
    bus(IDX_IRQ_EN, 1'b1, 8'h90);
    bus(IDX_IRQ_PRIO, 1'b1, 8'h10);
    bus(IDX_CONTROL, 1'b1, 8'h98);
    tx = 8'($urandom);
    rx = 8'($urandom);
    tq.push_back({1'b1, tx});
    listen <= 1'b1;
    bus(IDX_DATA, 1'b1, tx);
    u_node.send({1'b0, rx}, 1'b1);
    listen <= 1'b0;
    rd(IDX_CONTROL, 8'h9B, 8'hFF);
    rd(IDX_DATA, rx, 8'hFF);
    chk({irq, sreq, shigh}, 9'h007);
    bus(IDX_EVT_MASK, 1'b1, 8'h00);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    bus(IDX_EVT_STAT, 1'b1, 8'h07);
    bus(IDX_EVT_MASK, 1'b1, 8'h07);
    rd(IDX_EVT_STAT, 8'h00, 8'hFF);
    bus(IDX_GIVEN, 1'b1, 8'h50);
    for (int c = 0; c < 7; c++) begin
      bus(IDX_CONTROL, 1'b1, cs[c][15:8]);
      bus(IDX_MASK, 1'b1, cs[c][7:0]);
      u_node.send(fr[c], 1'b1);
      rd(IDX_CONTROL, ex[c], 8'hFB);
    end
    bus(IDX_CONTROL, 1'b1, 8'h90);
    bus(IDX_POWER, 1'b1, 8'h40);
    u_node.send(9'h0A5, 1'b0);
    rd(IDX_CONTROL, 8'h80, 8'h80);
    bus(IDX_CONTROL, 1'b1, 8'h10);
    rd(IDX_CONTROL, 8'h00, 8'h80);
    bus(IDX_POWER, 1'b1, 8'h00);
    for (int m = 0; m < 2; m++) begin
      bus(IDX_CONTROL, 1'b1, m ? 8'h20 : 8'h00);
      bus(IDX_DATA, 1'b1, 8'h3C);
      n = 0;
      while (txd !== 1'b0 && n < 50) begin
        @(negedge hclk);
        n++;
      end
      n = 0;
      do begin
        n++;
        @(negedge hclk);
      end while (txd === 1'b0 && n < 50);
      chk(9'(n), m ? 9'h002 : 9'h006);
      repeat (120) @(posedge hclk);
    end
    end_of_test();
  end
endmodule
